// ---- design/ccdpc_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef CCDPC_REGS_SVH
`define CCDPC_REGS_SVH

`define CCDPC_OFS_CTRL        8'h00
`define CCDPC_OFS_CLAMP_START 8'h04
`define CCDPC_OFS_CLAMP_STOP  8'h08
`define CCDPC_OFS_BLACK_PIX   8'h0C
`define CCDPC_OFS_TG_WIDTH    8'h10
`define CCDPC_OFS_STATUS      8'h14
`define CCDPC_OFS_PIX_COUNT   8'h18

`define CCDPC_CTRL_MODE_LSB   0
`define CCDPC_CTRL_THREE_BIT  2
`define CCDPC_CTRL_CIS_BIT    3

`define CCDPC_RST_CTRL        4'h4
`define CCDPC_RST_CLAMP_START 8'h10
`define CCDPC_RST_CLAMP_STOP  8'h04
`define CCDPC_RST_BLACK_PIX   8'h12
`define CCDPC_RST_TG_WIDTH    8'h04

`define CCDPC_CONV_DIV        5'h04
`define CCDPC_PIX_DIV_THREE   5'h0C
`define CCDPC_PIX_DIV_TWO     5'h08

`endif

// ---- design/ccdpc_pkg.sv ----
// Types shared by the preview and clamp timing block
package ccdpc_pkg;

	typedef enum logic [1:0] {
		CCDPC_MODE_NORMAL = 2'b00,
		CCDPC_MODE_X2     = 2'b01,
		CCDPC_MODE_X4     = 2'b10
	} ccdpc_mode_type;

	typedef enum logic [1:0] {
		CCDPC_ST_IDLE = 2'b00,
		CCDPC_ST_XFER = 2'b01,
		CCDPC_ST_RUN  = 2'b10
	} ccdpc_state_type;

endpackage

// ---- design/ccdpc_cfg_if.sv ----
// Configuration and status carrier between register slave and timing core
`timescale 1ns/1ps
interface ccdpc_cfg_if;
	import ccdpc_pkg::*;
	logic [1:0]     mode;
	logic           three_out;
	logic           cis;
	logic [7:0]     clamp_start;
	logic [7:0]     clamp_stop;
	logic [7:0]     black_pix;
	logic [7:0]     tg_width;
	logic           line_active;
	ccdpc_mode_type cur_mode;
	logic [15:0]    pix_count;

	modport regs (output mode, three_out, cis, clamp_start, clamp_stop, black_pix,
		tg_width, input line_active, cur_mode, pix_count);
	modport core (input mode, three_out, cis, clamp_start, clamp_stop, black_pix,
		tg_width, output line_active, cur_mode, pix_count);
endinterface

// ---- design/ccdpc_cnt.sv ----
// Modulo counter with synchronous clear
`timescale 1ns/1ps
module ccdpc_cnt #(
	parameter int W = 5
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         clr,
	input  wire logic [W-1:0] modulus,
	output logic      [W-1:0] cnt,
	output logic              last
);
	logic [W-1:0] cnt_r;
	logic [W-1:0] cnt_nxt;

	assign last = (cnt_r == modulus - W'(1));
	assign cnt  = cnt_r;

	always_comb begin
		cnt_nxt = cnt_r + W'(1);
		if (clr || last) begin
			cnt_nxt = '0;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_r <= '0;
		end else begin
			cnt_r <= cnt_nxt;
		end
	end
endmodule // ccdpc_cnt

// ---- design/ccdpc_axil.sv ----
// AXI4-Lite register slave for the timing block
`timescale 1ns/1ps
`include "ccdpc_regs.svh"
module ccdpc_axil
	import ccdpc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  awaddr,
	input  wire logic        awvalid,
	output logic             awready,
	input  wire logic [31:0] wdata,
	input  wire logic [3:0]  wstrb,
	input  wire logic        wvalid,
	output logic             wready,
	output logic [1:0]       bresp,
	output logic             bvalid,
	input  wire logic        bready,
	input  wire logic [7:0]  araddr,
	input  wire logic        arvalid,
	output logic             arready,
	output logic [31:0]      rdata,
	output logic [1:0]       rresp,
	output logic             rvalid,
	input  wire logic        rready,
	ccdpc_cfg_if.regs        cfg
);
	logic        aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
	logic [7:0]  waddr_r, waddr_nxt;
	logic [31:0] wdat_r, wdat_nxt;
	logic        bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
	logic [1:0]  bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [3:0]  ctrl_r, ctrl_nxt;
	logic [7:0]  cst_r, cst_nxt, csp_r, csp_nxt, blk_r, blk_nxt, tgw_r, tgw_nxt;
	logic        do_wr;

	assign awready = !aw_hold_r && !bvalid_r;
	assign wready  = !w_hold_r && !bvalid_r;
	assign arready = !rvalid_r;
	assign bvalid  = bvalid_r;
	assign bresp   = bresp_r;
	assign rvalid  = rvalid_r;
	assign rresp   = rresp_r;
	assign rdata   = rdata_r;
	assign cfg.mode        = ctrl_r[`CCDPC_CTRL_MODE_LSB +: 2];
	assign cfg.three_out   = ctrl_r[`CCDPC_CTRL_THREE_BIT];
	assign cfg.cis         = ctrl_r[`CCDPC_CTRL_CIS_BIT];
	assign cfg.clamp_start = cst_r;
	assign cfg.clamp_stop  = csp_r;
	assign cfg.black_pix   = blk_r;
	assign cfg.tg_width    = tgw_r;

	always_comb begin
		aw_hold_nxt = aw_hold_r;
		w_hold_nxt  = w_hold_r;
		waddr_nxt   = waddr_r;
		wdat_nxt    = wdat_r;
		bvalid_nxt  = bvalid_r && !bready;
		bresp_nxt   = bresp_r;
		ctrl_nxt    = ctrl_r;
		cst_nxt     = cst_r;
		csp_nxt     = csp_r;
		blk_nxt     = blk_r;
		tgw_nxt     = tgw_r;
		if (awvalid && awready) begin
			aw_hold_nxt = 1'b1;
			waddr_nxt   = awaddr;
		end
		if (wvalid && wready) begin
			w_hold_nxt = 1'b1;
			wdat_nxt   = wdata;
		end
		do_wr = aw_hold_r && w_hold_r;
		if (do_wr) begin
			aw_hold_nxt = 1'b0;
			w_hold_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = 2'h0;
			// Byte enables ignored: every field sits in lane 0
			if (waddr_r == `CCDPC_OFS_CTRL) begin
				ctrl_nxt = wdat_r[3:0];
			end else if (waddr_r == `CCDPC_OFS_CLAMP_START) begin
				cst_nxt = wdat_r[7:0];
			end else if (waddr_r == `CCDPC_OFS_CLAMP_STOP) begin
				csp_nxt = wdat_r[7:0];
			end else if (waddr_r == `CCDPC_OFS_BLACK_PIX) begin
				blk_nxt = wdat_r[7:0];
			end else if (waddr_r == `CCDPC_OFS_TG_WIDTH) begin
				tgw_nxt = wdat_r[7:0];
			end else if (waddr_r != `CCDPC_OFS_STATUS && waddr_r != `CCDPC_OFS_PIX_COUNT) begin
				bresp_nxt = 2'h2;
			end
		end
	end

	always_comb begin
		rvalid_nxt = rvalid_r && !rready;
		rdata_nxt  = rdata_r;
		rresp_nxt  = rresp_r;
		if (arvalid && arready) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = 2'h0;
			rdata_nxt  = 32'h0;
			if (araddr == `CCDPC_OFS_CTRL) begin
				rdata_nxt[3:0] = ctrl_r;
			end else if (araddr == `CCDPC_OFS_CLAMP_START) begin
				rdata_nxt[7:0] = cst_r;
			end else if (araddr == `CCDPC_OFS_CLAMP_STOP) begin
				rdata_nxt[7:0] = csp_r;
			end else if (araddr == `CCDPC_OFS_BLACK_PIX) begin
				rdata_nxt[7:0] = blk_r;
			end else if (araddr == `CCDPC_OFS_TG_WIDTH) begin
				rdata_nxt[7:0] = tgw_r;
			end else if (araddr == `CCDPC_OFS_STATUS) begin
				rdata_nxt[2:0] = {cfg.cur_mode, cfg.line_active};
			end else if (araddr == `CCDPC_OFS_PIX_COUNT) begin
				rdata_nxt[15:0] = cfg.pix_count;
			end else begin
				rresp_nxt = 2'h2;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_r <= 1'b0;
			w_hold_r  <= 1'b0;
			waddr_r   <= 8'h00;
			wdat_r    <= 32'h0;
			bvalid_r  <= 1'b0;
			bresp_r   <= 2'h0;
			rvalid_r  <= 1'b0;
			rresp_r   <= 2'h0;
			rdata_r   <= 32'h0;
			ctrl_r    <= `CCDPC_RST_CTRL;
			cst_r     <= `CCDPC_RST_CLAMP_START;
			csp_r     <= `CCDPC_RST_CLAMP_STOP;
			blk_r     <= `CCDPC_RST_BLACK_PIX;
			tgw_r     <= `CCDPC_RST_TG_WIDTH;
		end else begin
			aw_hold_r <= aw_hold_nxt;
			w_hold_r  <= w_hold_nxt;
			waddr_r   <= waddr_nxt;
			wdat_r    <= wdat_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
			ctrl_r    <= ctrl_nxt;
			cst_r     <= cst_nxt;
			csp_r     <= csp_nxt;
			blk_r     <= blk_nxt;
			tgw_r     <= tgw_nxt;
		end
	end
endmodule // ccdpc_axil

// ---- design/ccdpc_top.sv ----
// Sensor shift clock, reset gate, transfer gate and clamp timing
// Operation
// - Preview modes apply only to charge-coupled sensors; a contact sensor setting forces normal.
// - Two preview modes halve or quarter resolution by summing adjacent pixels on the sensor.
// - In x2 the shift clock runs twice as fast while the reset gate stays at pixel rate.
// - In x2 every second reset gate pulse is dropped so two pixels sum before sampling.
// - In x4 the shift clock runs four times as fast with the reset gate at pixel rate.
// - In x4 three of every four reset gate pulses are dropped, combining four pixels.
// - The faster shift clock shortens line period and integration to one half or one quarter.
// - The input clamp closes during each optical-black pixel between programmed start and stop.
// - Clamp-on time per pixel equals start minus stop in half master-clock periods.
// - Pixel rate per channel is master clock over 12 for three outputs and over 8 for two.
// - Clamping during the black pixels at line start restores the video input to mid level.
// - Conversion runs at one quarter of the master clock and all timing derives from it; here shift and pixel dividers count the master clock directly.
// - Line start rising gives a transfer gate pulse, then pixels convert until line start falls.
//
// Our own choices: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "ccdpc_regs.svh"
module ccdpc_top
	import ccdpc_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        line_start,
	output logic             shift_clk,
	output logic             reset_gate_pulse,
	output logic             transfer_gate_pulse,
	output logic             clamp_on,
	output logic             convert_strobe,
	output logic             line_active
);
	ccdpc_cfg_if cfg ();

	ccdpc_state_type state_r, state_nxt;
	ccdpc_mode_type  mode_r, mode_nxt;
	ccdpc_mode_type  mode_sel;
	logic            three_r, three_nxt;
	logic            ls_d_r, ls_d_nxt;
	logic            line_rise;
	logic [7:0]      tg_cnt_r, tg_cnt_nxt;
	// Line settings frozen at line start
	logic [7:0]      tg_len_r, tg_len_nxt;
	logic [7:0]      blk_r, blk_nxt;
	logic [7:0]      cst_r, cst_nxt;
	logic [7:0]      csp_r, csp_nxt;
	logic [15:0]     pix_r, pix_nxt;
	logic            sh_r, sh_nxt;
	logic            rg_r, rg_nxt;
	logic            tg_r, tg_nxt;
	logic            cl_r, cl_nxt;
	logic            cv_r, cv_nxt;
	logic            run;
	logic [4:0]      pix_div;
	logic [4:0]      shift_div;
	logic [4:0]      pcnt;
	logic [4:0]      scnt;
	logic            pix_last;
	logic [7:0]      hpos;
	logic [4:0]      ccnt;
	logic            shift_high;
	logic            pix_start;
	logic            conv_slot;
	logic            in_black;
	logic            in_window;

	// ------------------------------------------------------------
	// Register slave
	// ------------------------------------------------------------
	ccdpc_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.cfg     (cfg)
	);

	assign cfg.line_active = (state_r != CCDPC_ST_IDLE);
	assign cfg.cur_mode    = mode_r;
	assign cfg.pix_count   = pix_r;

	// ------------------------------------------------------------
	// Dividers
	// ------------------------------------------------------------
	assign run     = (state_r == CCDPC_ST_RUN);
	assign pix_div = three_r ? `CCDPC_PIX_DIV_THREE : `CCDPC_PIX_DIV_TWO;

	// Both counters clear together, so each pixel opens on a shift edge
	// Three outputs at x4 give an odd shift period with a one-cycle high phase
	// Shift period is the pixel period cut by the preview factor
	always_comb begin
		case (mode_r)
			CCDPC_MODE_X2: shift_div = pix_div >> 1;
			CCDPC_MODE_X4: shift_div = pix_div >> 2;
			default:       shift_div = pix_div;
		endcase
	end

	ccdpc_cnt #(.W(5)) u_pix (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (!run),
		.modulus (pix_div),
		.cnt     (pcnt),
		.last    (pix_last)
	);

	ccdpc_cnt #(.W(5)) u_shift (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (!run),
		.modulus (shift_div),
		.cnt     (scnt),
		.last    ()
	);

	// Conversion slots come from their own divider, fixed in every mode
	// Pixel periods are whole multiples of it, so slots never drift
	ccdpc_cnt #(.W(5)) u_conv (
		.aclk    (aclk),
		.aresetn (aresetn),
		.clr     (!run),
		.modulus (`CCDPC_CONV_DIV),
		.cnt     (ccnt),
		.last    ()
	);

	// Clamp positions are in half master-clock units
	assign hpos = {2'b00, pcnt, 1'b0};

	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	// A contact sensor has no charge node to sum on, so it stays normal
	// Code 3 is reserved and falls back to normal
	always_comb begin
		mode_sel = CCDPC_MODE_NORMAL;
		if (!cfg.cis) begin
			case (cfg.mode)
				2'b01:   mode_sel = CCDPC_MODE_X2;
				2'b10:   mode_sel = CCDPC_MODE_X4;
				default: mode_sel = CCDPC_MODE_NORMAL;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Line sequencer
	// ------------------------------------------------------------
	// Pin idles low, so the delayed copy cannot fake an edge after reset
	assign line_rise = line_start && !ls_d_r;

	always_comb begin
		state_nxt  = state_r;
		mode_nxt   = mode_r;
		three_nxt  = three_r;
		ls_d_nxt   = line_start;
		tg_cnt_nxt = tg_cnt_r;
		tg_len_nxt = tg_len_r;
		blk_nxt    = blk_r;
		cst_nxt    = cst_r;
		csp_nxt    = csp_r;
		pix_nxt    = pix_r;
		case (state_r)
			CCDPC_ST_IDLE: begin
				if (line_rise) begin
					state_nxt  = CCDPC_ST_XFER;
					tg_cnt_nxt = 8'h00;
					pix_nxt    = 16'h0000;
					// Latched here only, never mid-line
					three_nxt  = cfg.three_out;
					mode_nxt   = mode_sel;
					// Line geometry is frozen too, so a write cannot tear a line
					tg_len_nxt = cfg.tg_width;
					blk_nxt    = cfg.black_pix;
					cst_nxt    = cfg.clamp_start;
					csp_nxt    = cfg.clamp_stop;
				end
			end
			CCDPC_ST_XFER: begin
				tg_cnt_nxt = tg_cnt_r + 8'h01;
				// A width of zero still gives a one-cycle pulse
				if (tg_cnt_r + 8'h01 >= tg_len_r) begin
					state_nxt = line_start ? CCDPC_ST_RUN : CCDPC_ST_IDLE;
				end
			end
			CCDPC_ST_RUN: begin
				// Pixel index feeds the black window and the count register
				if (pix_last) begin
					pix_nxt = pix_r + 16'h0001;
				end
				if (!line_start) begin
					state_nxt = CCDPC_ST_IDLE;
				end
			end
			default: state_nxt = CCDPC_ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Sensor pulses
	// ------------------------------------------------------------
	// High for the first half of every shift period
	assign shift_high = (scnt < (shift_div >> 1));
	// Candidate at each shift period, kept only at the pixel start
	assign pix_start  = (scnt == 5'h00) && (pcnt == 5'h00);
	assign conv_slot  = (ccnt == 5'h00);
	assign in_black   = (pix_r < {8'h00, blk_r});
	// Odd half positions round to the cycle grid
	assign in_window  = (hpos >= csp_r) && (hpos < cst_r);

	// Clamp needs both a black pixel and the programmed slot
	always_comb begin
		tg_nxt = (state_nxt == CCDPC_ST_XFER);
		sh_nxt = run && shift_high;
		rg_nxt = run && pix_start;
		cv_nxt = run && conv_slot;
		cl_nxt = run && in_black && in_window;
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign shift_clk           = sh_r;
	assign reset_gate_pulse    = rg_r;
	assign transfer_gate_pulse = tg_r;
	assign clamp_on            = cl_r;
	assign convert_strobe      = cv_r;
	assign line_active         = cfg.line_active;

	// Sequencer state and the settings frozen for this line
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r  <= CCDPC_ST_IDLE;
			mode_r   <= CCDPC_MODE_NORMAL;
			three_r  <= 1'b1;
			ls_d_r   <= 1'b0;
			tg_cnt_r <= 8'h00;
			tg_len_r <= `CCDPC_RST_TG_WIDTH;
			blk_r    <= `CCDPC_RST_BLACK_PIX;
			cst_r    <= `CCDPC_RST_CLAMP_START;
			csp_r    <= `CCDPC_RST_CLAMP_STOP;
			pix_r    <= 16'h0000;
		end else begin
			state_r  <= state_nxt;
			mode_r   <= mode_nxt;
			three_r  <= three_nxt;
			ls_d_r   <= ls_d_nxt;
			tg_cnt_r <= tg_cnt_nxt;
			tg_len_r <= tg_len_nxt;
			blk_r    <= blk_nxt;
			cst_r    <= cst_nxt;
			csp_r    <= csp_nxt;
			pix_r    <= pix_nxt;
		end
	end

	// Pulses are registered so the sensor sees glitch-free edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sh_r <= 1'b0;
			rg_r <= 1'b0;
			tg_r <= 1'b0;
			cl_r <= 1'b0;
			cv_r <= 1'b0;
		end else begin
			sh_r <= sh_nxt;
			rg_r <= rg_nxt;
			tg_r <= tg_nxt;
			cl_r <= cl_nxt;
			cv_r <= cv_nxt;
		end
	end
endmodule // ccdpc_top

// ---- sim/ccdpc_top_checker.sv ----
// Port assertions for the preview and clamp timing block
`timescale 1ns/1ps
module ccdpc_top_checker (
	input logic aclk,
	input logic aresetn,
	input logic line_start,
	input logic shift_clk,
	input logic reset_gate_pulse,
	input logic transfer_gate_pulse,
	input logic clamp_on,
	input logic convert_strobe,
	input logic line_active,
	input logic s_axi_arvalid,
	input logic s_axi_arready,
	input logic s_axi_rvalid
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// ------------------------------
	// Sensor timing
	// ------------------------------
	AST_RG_GAP: assert property (reset_gate_pulse |=> !reset_gate_pulse [*7])
		else $error("reset gate pulses closer than a pixel");
	AST_RG_SHIFT: assert property (reset_gate_pulse |-> shift_clk)
		else $error("reset gate off the shift edge");
	AST_CV_GAP: assert property (convert_strobe |=> !convert_strobe [*3])
		else $error("convert strobes too close");
	AST_CV_NEXT: assert property ((convert_strobe && line_start) ##1 line_start [*3]
		|=> convert_strobe)
		else $error("convert strobe missing after 4 cycles");
	AST_TG_START: assert property ($rose(line_start) && !line_active
		|-> ##[1:2] transfer_gate_pulse)
		else $error("no transfer gate after line start");
	AST_TG_RUN: assert property ($fell(transfer_gate_pulse) && line_start && $past(line_start)
		##1 line_start
		|-> ##[0:2] reset_gate_pulse)
		else $error("pixels did not start after transfer gate");
	AST_TG_QUIET: assert property (transfer_gate_pulse
		|-> !(shift_clk || reset_gate_pulse || convert_strobe || clamp_on))
		else $error("pixel outputs during transfer gate");
	// Two idle samples, since outputs may lag the state by one edge
	AST_IDLE: assert property (!line_active ##1 !line_active
		|-> !(shift_clk || reset_gate_pulse || convert_strobe || clamp_on))
		else $error("pixel outputs while idle");
	AST_END: assert property ($fell(line_start) && !transfer_gate_pulse
		|-> ##[1:4] !line_active)
		else $error("line did not end");
	AST_RD_ANSWER: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule // ccdpc_top_checker

bind ccdpc_top ccdpc_top_checker u_chk (.aclk, .aresetn, .line_start, .shift_clk,
	.reset_gate_pulse, .transfer_gate_pulse, .clamp_on, .convert_strobe, .line_active,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rvalid);

// ---- sim/ccdpc_sensor_model.sv ----
// Behavioural linear sensor summing charge between reset gate pulses
`timescale 1ns/1ps
module ccdpc_sensor_model (
	input  logic       aclk,
	input  logic       aresetn,
	input  logic       shift_clk,
	input  logic       reset_gate_pulse,
	input  logic       transfer_gate_pulse,
	output logic [3:0] last_sum
);
	logic       prev_sh;
	logic [3:0] acc;
	logic       rise;

	assign rise = shift_clk && !prev_sh;

	// Every shifted pixel piles on the node until the reset gate clears it
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_sh <= 1'b0;
			acc <= 4'h0;
			last_sum <= 4'h0;
		end else begin
			prev_sh <= shift_clk;
			if (transfer_gate_pulse) begin
				acc <= 4'h0;
			end else if (reset_gate_pulse) begin
				last_sum <= acc;
				acc <= {3'h0, rise};
			end else begin
				acc <= acc + {3'h0, rise};
			end
		end
	end
endmodule // ccdpc_sensor_model

// ---- sim/ccd_preview_clamp_timing_tb_top.sv ----
// Self-checking bench: registers, preview modes and clamp window
`timescale 1ns/1ps
`include "ccdpc_regs.svh"
module ccd_preview_clamp_timing_tb_top;
	logic        aclk, shift_clk, reset_gate_pulse, transfer_gate_pulse;
	logic        clamp_on, convert_strobe, line_active, s_axi_awready, s_axi_wready;
	logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic        aresetn = 1'b0, line_start = 1'b0, s_axi_awvalid = 1'b0;
	logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
	logic        s_axi_rready = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF, last_sum;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	int          fail_count = 0, checked = 0;
	// Columns: control, transfer width, black pixels, clamp start, clamp stop
	logic [7:0]  cs [8][5] = '{'{8'h04, 8'h04, 8'h12, 8'h10, 8'h04},
		'{8'h05, 8'h01, 8'h12, 8'h10, 8'h04}, '{8'h06, 8'h02, 8'h12, 8'h10, 8'h04},
		'{8'h00, 8'h03, 8'h12, 8'h08, 8'h02}, '{8'h01, 8'h04, 8'h12, 8'h08, 8'h02},
		'{8'h02, 8'h05, 8'h12, 8'h08, 8'h02}, '{8'h0E, 8'h04, 8'h02, 8'h10, 8'h04},
		'{8'h03, 8'h01, 8'h01, 8'h08, 8'h02}};
	logic [31:0] rst_val [8] = '{32'h4, 32'h10, 32'h4, 32'h12, 32'h4, 32'h0, 32'h0, 32'h0};

	ccdpc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_start, .shift_clk,
		.reset_gate_pulse, .transfer_gate_pulse, .clamp_on, .convert_strobe, .line_active);
	ccdpc_sensor_model u_ccd (.aclk, .aresetn, .shift_clk, .reset_gate_pulse,
		.transfer_gate_pulse, .last_sum);

	initial begin
		aclk = 1'b0;
		forever #10 aclk = ~aclk;
	end

	// ------------------------------
	// Tasks
	// ------------------------------
	task automatic close_out;
		$display("Comparisons %0d mismatches %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR %0t %s got %0h exp %0h", $time, what, got, exp);
		end
	endtask

	task automatic tmo(input string what);
		fail_count++;
		$display("ERROR %0t timeout %s", $time, what);
		close_out();
	endtask

	// Address and data offered together, each released once taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		bit ad, wd, got;
		ad = 0;
		wd = 0;
		got = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge aclk);
			if (s_axi_bvalid === 1'b1) begin
				got = 1;
				chk(32'(s_axi_bresp), 32'(er), "bresp");
			end
			if (!ad && s_axi_awready === 1'b1) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!wd && s_axi_wready === 1'b1) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		s_axi_bready <= 1'b0;
		if (!got) tmo("write");
	endtask

	task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		bit got;
		got = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (int n = 0; n < 40 && !got; n++) begin
			@(posedge aclk);
			if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid === 1'b1) begin
				got = 1;
				chk(s_axi_rdata, ed, "rdata");
				chk(32'(s_axi_rresp), 32'(er), "rresp");
			end
		end
		s_axi_rready <= 1'b0;
		if (!got) tmo("read");
	endtask

	// One line: 48 cycles from the first pixel edge span whole pixels for P of 8 and 12
	task automatic run_line(input logic [7:0] c, tg, blk, st, sp);
		int p, m, tgc, sh, rg, cv, cl, np;
		bit prv;
		p = c[2] ? 12 : 8;
		m = (c[3] || c[1:0] == 2'h3) ? 0 : int'(c[1:0]);
		np = (48 / p < blk) ? 48 / p : int'(blk);
		{tgc, sh, rg, cv, cl, prv} = '0;
		axw(`CCDPC_OFS_CTRL, 32'(c), 2'h0);
		axw(`CCDPC_OFS_TG_WIDTH, 32'(tg), 2'h0);
		axw(`CCDPC_OFS_BLACK_PIX, 32'(blk), 2'h0);
		axw(`CCDPC_OFS_CLAMP_START, 32'(st), 2'h0);
		axw(`CCDPC_OFS_CLAMP_STOP, 32'(sp), 2'h0);
		@(posedge aclk);
		line_start <= 1'b1;
		for (int n = 0; n < 400 && reset_gate_pulse !== 1'b1; n++) begin
			@(posedge aclk);
			tgc += int'(transfer_gate_pulse === 1'b1);
		end
		if (reset_gate_pulse !== 1'b1) tmo("pixels");
		for (int k = 0; k < 48; k++) begin
			sh += int'(shift_clk === 1'b1 && !prv);
			prv = (shift_clk === 1'b1);
			rg += int'(reset_gate_pulse === 1'b1);
			cv += int'(convert_strobe === 1'b1);
			cl += int'(clamp_on === 1'b1);
			@(posedge aclk);
		end
		chk(32'(tgc), 32'(tg), "tg width");
		chk(32'(sh), 32'(48 / (p >> m)), "shift edges");
		chk(32'(rg), 32'(48 / p), "reset gates");
		chk(32'(cv), 32'hC, "converts");
		chk(32'(cl), 32'(np * (st - sp) / 2), "clamp");
		chk(32'(last_sum), 32'(1 << m), "summed pixels");
		axw(`CCDPC_OFS_CTRL, 32'(c ^ 8'h01), 2'h0);
		axr(`CCDPC_OFS_STATUS, 32'(m * 2 + 1), 2'h0);
		repeat (2 * p) @(posedge aclk);
		chk(32'(last_sum), 32'(1 << m), "sum after change");
		line_start <= 1'b0;
		for (int n = 0; n < 20 && line_active !== 1'b0; n++) @(posedge aclk);
		if (line_active !== 1'b0) tmo("line end");
	endtask

	// ------------------------------
	// Main sequence
	// ------------------------------
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			axr(8'(i * 4), rst_val[i], (i == 7) ? 2'h2 : 2'h0);
		end
		axw(8'h1C, 32'h5A, 2'h2);
		axw(`CCDPC_OFS_STATUS, 32'h7, 2'h0);
		axr(`CCDPC_OFS_STATUS, 32'h0, 2'h0);
		for (int i = 0; i < 8; i++) begin
			run_line(cs[i][0], cs[i][1], cs[i][2], cs[i][3], cs[i][4]);
		end
		close_out();
	end
endmodule // ccd_preview_clamp_timing_tb_top
